// File: core/ebcs_pkg.sv
// package of offsets, fields and reset values for the chip-select decoder
package ebcs_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] EBCS_OFF_MODE   = 12'h000;
  localparam logic [11:0] EBCS_OFF_WIN0   = 12'h010;
  localparam logic [11:0] EBCS_OFF_WIN1   = 12'h014;
  localparam logic [11:0] EBCS_OFF_WIN2   = 12'h018;
  localparam logic [11:0] EBCS_OFF_WIN3   = 12'h01C;
  localparam logic [11:0] EBCS_OFF_ENABLE = 12'h080;
  localparam logic [11:0] EBCS_OFF_STATUS = 12'h084;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EBCS_MODE_SEL_BIT  = 0;
  localparam int EBCS_MODE_STR_LSB  = 1;
  localparam int EBCS_MODE_STR_MSB  = 2;
  localparam int EBCS_WIN_BASE_LSB  = 16;
  localparam int EBCS_WIN_BASE_MSB  = 31;
  localparam int EBCS_WIN_SIZE_LSB  = 0;
  localparam int EBCS_WIN_SIZE_MSB  = 7;
  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] EBCS_RST_MODE   = 32'h0000_0000;
  localparam logic [31:0] EBCS_RST_WIN    = 32'h0000_0000;
  localparam logic [3:0]  EBCS_RST_ENABLE = 4'h0;
  localparam logic [7:0]  EBCS_SIZE_MAX   = 8'h08;
  localparam int          EBCS_NCH        = 4;
  localparam int          EBCS_CNT_W      = 8;
  typedef enum logic [1:0] {
    EBCS_STR_X1  = 2'h0,
    EBCS_STR_X2  = 2'h1,
    EBCS_STR_X4  = 2'h2,
    EBCS_STR_BAD = 2'h3
  } ebcs_stretch_t;
endpackage

// File: core/ebcs_stretch.sv
// count scaler applying the global bus-cycle stretch factor
`timescale 1ns/1ps
`default_nettype none
module ebcs_stretch
  import ebcs_pkg::*;
#(
  parameter int CW = 8
) (
  input  wire logic [CW-1:0]        count_in,
  input  wire ebcs_pkg::ebcs_stretch_t factor,
  output logic      [CW+1:0]        count_out
);
  import ebcs_pkg::*;

  // ----------------------------------------------------------------
  // scaling
  // ----------------------------------------------------------------
  // x1, x2 or x4 shift
  // prohibited code falls back to x1 so a bad write cannot stall a bus
  always_comb begin
    case (factor)
      EBCS_STR_X2: count_out = {1'b0, count_in, 1'b0};
      EBCS_STR_X4: count_out = {count_in, 2'b00};
      default:     count_out = {2'b00, count_in};
    endcase
  end
endmodule
`default_nettype wire

// File: core/ebcs_decoder.sv
// external bus chip-select decoder with apb register file
`timescale 1ns/1ps
`default_nettype none
module ebcs_decoder
  import ebcs_pkg::*;
#(
  parameter int CW = ebcs_pkg::EBCS_CNT_W
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [31:0]   bus_addr,
  input  wire logic          bus_valid,
  output logic               chip_select_0_n,
  output logic               chip_select_1_n,
  output logic               chip_select_2_n,
  output logic               chip_select_3_n,
  input  wire logic [CW-1:0] count_in,
  output logic      [CW+1:0] count_out,
  output logic      [1:0]    stretch_factor
);
  import ebcs_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // window hit: base compared on the bits above the window size only
  function automatic logic win_hit(input logic [31:0] a,
                                   input logic [15:0] base,
                                   input logic [7:0]  code);
    logic [15:0] mask;
    mask = 16'h0000;
    if (code > EBCS_SIZE_MAX)
      return 1'b0;
    mask = ~(16'hFFFF >> (5'd8 + code[4:0]));
    return ((a[31:16] ^ base) & mask) == 16'h0000;
  endfunction

  function automatic logic known_addr(input logic [11:0] a);
    case (a)
      EBCS_OFF_MODE, EBCS_OFF_WIN0, EBCS_OFF_WIN1, EBCS_OFF_WIN2,
      EBCS_OFF_WIN3, EBCS_OFF_ENABLE, EBCS_OFF_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0]  stretch_q;
  logic        bus_sel_q;
  logic [15:0] base_q [EBCS_NCH];
  logic [7:0]  size_q [EBCS_NCH];
  logic [3:0]  enable_q;
  logic [3:0]  cs_n_q;
  logic [3:0]  hit_vec;
  logic [3:0]  grant;
  logic [CW+1:0] scaled;
  logic [31:0] rdata_q;
  logic        wr_en;
  logic        setup_rd;

  assign wr_en    = psel & penable & pwrite & known_addr(paddr);
  assign setup_rd = psel & ~penable & ~pwrite;
  // zero-wait slave; unmapped offsets answer with an error
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~known_addr(paddr);
  assign prdata   = rdata_q;

  // mode register: stretch factor and bus mode select
  // select bit stored as written, software must keep it zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_q <= EBCS_RST_MODE[EBCS_MODE_STR_MSB:EBCS_MODE_STR_LSB];
      bus_sel_q <= EBCS_RST_MODE[EBCS_MODE_SEL_BIT];
    end else if (wr_en && paddr == EBCS_OFF_MODE) begin
      stretch_q <= pwdata[EBCS_MODE_STR_MSB:EBCS_MODE_STR_LSB];
      bus_sel_q <= pwdata[EBCS_MODE_SEL_BIT];
    end
  end

  // window registers, one word each
  // base bits stored in 31-16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < EBCS_NCH; i++) begin
        base_q[i] <= EBCS_RST_WIN[EBCS_WIN_BASE_MSB:EBCS_WIN_BASE_LSB];
        size_q[i] <= EBCS_RST_WIN[EBCS_WIN_SIZE_MSB:EBCS_WIN_SIZE_LSB];
      end
    end else begin
      for (int i = 0; i < EBCS_NCH; i++) begin
        if (wr_en && paddr == EBCS_OFF_WIN0 + 12'(4 * i)) begin
          base_q[i] <= pwdata[EBCS_WIN_BASE_MSB:EBCS_WIN_BASE_LSB];
          size_q[i] <= pwdata[EBCS_WIN_SIZE_MSB:EBCS_WIN_SIZE_LSB];
        end
      end
    end
  end

  // per-channel enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      enable_q <= EBCS_RST_ENABLE;
    else if (wr_en && paddr == EBCS_OFF_ENABLE)
      enable_q <= pwdata[3:0];
  end

  // read data captured in the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      case (paddr)
        EBCS_OFF_MODE:   rdata_q <= {29'h0, stretch_q, bus_sel_q};
        EBCS_OFF_WIN0:   rdata_q <= {base_q[0], 8'h00, size_q[0]};
        EBCS_OFF_WIN1:   rdata_q <= {base_q[1], 8'h00, size_q[1]};
        EBCS_OFF_WIN2:   rdata_q <= {base_q[2], 8'h00, size_q[2]};
        EBCS_OFF_WIN3:   rdata_q <= {base_q[3], 8'h00, size_q[3]};
        EBCS_OFF_ENABLE: rdata_q <= {28'h0, enable_q};
        EBCS_OFF_STATUS: rdata_q <= {28'h0, ~cs_n_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // masked compare per window
  always_comb begin
    for (int i = 0; i < EBCS_NCH; i++)
      hit_vec[i] = bus_valid & enable_q[i]
                   & win_hit(bus_addr, base_q[i], size_q[i]);
  end

  always_comb begin
    grant = 4'h0;
    if (hit_vec[0])      grant = 4'h1;
    else if (hit_vec[1]) grant = 4'h2;
    else if (hit_vec[2]) grant = 4'h4;
    else if (hit_vec[3]) grant = 4'h8;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cs_n_q <= 4'hF;
    else
      cs_n_q <= ~grant;
  end

  assign chip_select_0_n = cs_n_q[0];
  assign chip_select_1_n = cs_n_q[1];
  assign chip_select_2_n = cs_n_q[2];
  assign chip_select_3_n = cs_n_q[3];

  // ----------------------------------------------------------------
  // stretch path
  // ----------------------------------------------------------------
  // one scaler shared by every count the sequencer presents
  ebcs_stretch #(.CW(CW)) u_stretch (
    .count_in  (count_in),
    .factor    (ebcs_stretch_t'(stretch_q)),
    .count_out (scaled)
  );

  // registered so the sequencer sees a clean value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count_out <= '0;
    else
      count_out <= scaled;
  end

  assign stretch_factor = stretch_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_mode_wr;
    wr_en && paddr == EBCS_OFF_MODE;
  endsequence

  stretch_x2_a: assert property (@(posedge pclk) disable iff (!presetn)
    stretch_q == 2'h1 |=> count_out == {1'b0, $past(count_in), 1'b0})
    else $error("double stretch wrong");

  stretch_x4_a: assert property (@(posedge pclk) disable iff (!presetn)
    stretch_q == 2'h2 |=> count_out == {$past(count_in), 2'b00})
    else $error("quad stretch wrong");

  stretch_take_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_mode_wr |=> stretch_factor == $past(pwdata[2:1]))
    else $error("stretch not updated");

  base_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == EBCS_OFF_WIN1 |=> base_q[1] == $past(pwdata[31:16]))
    else $error("window base not stored");

  size_bad_a: assert property (@(posedge pclk) disable iff (!presetn)
    size_q[0] > EBCS_SIZE_MAX |-> !hit_vec[0])
    else $error("prohibited size code matched");

  mask_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_valid && enable_q[0] && size_q[0] == 8'h00
      && bus_addr[31:24] == base_q[0][15:8] |=> !chip_select_0_n)
    else $error("16M window missed");

  prio_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit_vec[0] |=> !chip_select_0_n && chip_select_1_n
                   && chip_select_2_n && chip_select_3_n)
    else $error("priority not honoured");

  idle_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    hit_vec == 4'h0 |=> cs_n_q == 4'hF)
    else $error("select active without match");
endmodule
`default_nettype wire

// File: bench/ebcs_ext_mem.sv
// model of the external devices hanging on the four selects
`timescale 1ns/1ps
`default_nettype none
module ebcs_ext_mem (
  input  wire logic [3:0] cs_n,
  output logic      [3:0] active,
  output logic            clash
);
  // one device per select
  // a device answers while its select is low; two at once would fight
  assign active = ~cs_n;
  assign clash  = (active & (active - 4'h1)) != 4'h0;
endmodule
`default_nettype wire

// File: bench/ebcs_test.sv
// self-checking bench for the chip-select decoder
`timescale 1ns/1ps
`default_nettype none
module ext_bus_chip_select_decoder_test;
  import ebcs_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and design
  // ----------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        bus_valid = 0, pready, pslverr, clash;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, bus_addr = '0, prdata;
  logic        cs0_n, cs1_n, cs2_n, cs3_n;
  logic [7:0]  count_in = '0;
  logic [9:0]  count_out;
  logic [1:0]  stretch_factor;
  logic [3:0]  active;
  int          err_count = 0, n_checks = 0;
  // free-running 25 MHz clock
  always #20 pclk = ~pclk;
  ebcs_decoder u_ebcs_decoder (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_addr(bus_addr), .bus_valid(bus_valid), .chip_select_0_n(cs0_n),
    .chip_select_1_n(cs1_n), .chip_select_2_n(cs2_n),
    .chip_select_3_n(cs3_n), .count_in(count_in), .count_out(count_out),
    .stretch_factor(stretch_factor));
  ebcs_ext_mem u_ebcs_ext_mem (.cs_n({cs3_n, cs2_n, cs1_n, cs0_n}),
    .active(active), .clash(clash));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    logic        x;
    apb(1'b0, a, 32'h0000_0000, q, x);
    chk(nm, e, q);
    chk("slverr", 32'h0000_0000, {31'h0, x});
  endtask
  // selects are registered: look one edge after the address lands
  task automatic dec(input logic [31:0] a, input logic v,
                     input logic [3:0] e);
    @(posedge pclk);
    bus_addr <= a;
    bus_valid <= v;
    @(posedge pclk);
    #1;
    chk("selects", {28'h0, e}, {28'h0, active});
    chk("clash", 32'h0000_0000, {31'h0, clash});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdc("mode", EBCS_OFF_MODE, EBCS_RST_MODE);
    for (int i = 0; i < 4; i++)
      rdc("window", EBCS_OFF_WIN0 + 12'(4 * i), EBCS_RST_WIN);
    rdc("enable", EBCS_OFF_ENABLE, 32'h0000_0000);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    wr(EBCS_OFF_MODE, 32'hFFFF_FFFC);
    rdc("mode", EBCS_OFF_MODE, 32'h0000_0004);
    wr(EBCS_OFF_WIN1, 32'h6100_FF08);
    rdc("window", EBCS_OFF_WIN1, 32'h6100_0008);
    apb(1'b0, 12'h040, 32'h0000_0000, q, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, q);
  endtask
  task automatic t_stretch;
    for (int k = 0; k < 3; k++) begin
      wr(EBCS_OFF_MODE, 32'(k) << 1);
      @(posedge pclk);
      count_in <= 8'hFF;
      @(posedge pclk);
      #1;
      chk("count", {22'h0, 10'h0FF << k}, {22'h0, count_out});
      chk("factor", 32'(k), {30'h0, stretch_factor});
    end
  endtask
  task automatic t_decode;
    wr(EBCS_OFF_WIN0, 32'h6000_0000);
    wr(EBCS_OFF_WIN1, 32'h6000_0008);
    wr(EBCS_OFF_ENABLE, 32'h0000_000F);
    dec(32'h6000_1234, 1'b1, 4'h1);
    dec(32'h60FF_FFFF, 1'b1, 4'h1);
    dec(32'h6100_0000, 1'b1, 4'h0);
    dec(32'h6000_1234, 1'b0, 4'h0);
    wr(EBCS_OFF_ENABLE, 32'h0000_000E);
    dec(32'h6000_FFFF, 1'b1, 4'h2);
    rdc("status", EBCS_OFF_STATUS, 32'h0000_0002);
    dec(32'h6001_0000, 1'b1, 4'h0);
  endtask
  // every size code, probing the last byte inside and the first outside
  task automatic t_sizes;
    logic [31:0] sz;
    wr(EBCS_OFF_ENABLE, 32'h0000_0004);
    for (int c = 0; c < 9; c++) begin
      sz = 32'h0100_0000 >> c;
      wr(EBCS_OFF_WIN2, 32'h6000_0000 | 32'(c));
      dec(32'h6000_0000 + sz - 1, 1'b1, 4'h4);
      dec(32'h6000_0000 + sz, 1'b1, 4'h0);
    end
    // a code past the last size is kept but must never select
    wr(EBCS_OFF_WIN0, 32'h6000_0009);
    wr(EBCS_OFF_ENABLE, 32'h0000_0001);
    rdc("window", EBCS_OFF_WIN0, 32'h6000_0009);
    dec(32'h6000_0000, 1'b1, 4'h0);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_stretch;
    t_decode;
    t_sizes;
    give_verdict;
  end
  // whole run needs well under 2000 cycles
  initial begin
    #400000;
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
